// *** hw/lcig_pkg.sv ***
// Package for the logic cell input gating block: register map and fields.
// Assumes an AXI4-Lite master with 32-bit data; registers are byte wide.
package lcig_pkg;
  localparam int ADDR_W = 8;
  localparam int SRC_SEL_W = 6;
  localparam int NUM_CHAN = 4;
  localparam int GATE_EN_W = 8;
  localparam int NUM_SRC = 64;

  // Byte addresses of the register words
  localparam logic [7:0] OFF_DATA1_SEL = 8'h00;
  localparam logic [7:0] OFF_DATA2_SEL = 8'h04;
  localparam logic [7:0] OFF_DATA3_SEL = 8'h08;
  localparam logic [7:0] OFF_DATA4_SEL = 8'h0c;
  localparam logic [7:0] OFF_GATE1_EN = 8'h10;
  localparam logic [7:0] OFF_GATE2_EN = 8'h14;
  localparam logic [7:0] OFF_CELL_CTL = 8'h18;
  localparam logic [7:0] OFF_POLARITY = 8'h1c;
  localparam logic [7:0] OFF_STATUS = 8'h20;

  // Cell control: enable at bit 7; bits 4..0 stored, 6..5 read zero
  localparam int CTL_EN_BIT = 7;
  localparam logic [7:0] CTL_MASK = 8'h9f;
  localparam logic [7:0] CTL_RESET = 8'h00;
  // Polarity register: gate1_invert at bit 0, gate2_invert at bit 1
  localparam int POL_G1_BIT = 0;
  localparam int POL_G2_BIT = 1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : lcig_pkg

// *** hw/lcig_gate.sv ***
// One data gate: ORs the enabled true and negated channel forms.
// Assumes the enable byte is ordered chan4 true at bit 7 down to
// chan1 negated at bit 0.
`timescale 1ns/1ps
module lcig_gate #(
  parameter int NUM_CHAN = 4
) (
  // Channel values and per-form enables
  input wire logic [NUM_CHAN-1:0] chan_true_i,
  input wire logic [2*NUM_CHAN-1:0] gate_en_i,
  // Combined gate level, before polarity
  output logic gate_o
);
  logic [2*NUM_CHAN-1:0] forms;

  genvar k;
  generate
    for (k = 0; k < NUM_CHAN; k++) begin : g_form
      // Odd bit is the true form, even bit the negated one
      assign forms[2*k+1] = chan_true_i[k] & gate_en_i[2*k+1]; // [RULE_04]
      assign forms[2*k] = ~chan_true_i[k] & gate_en_i[2*k]; // [RULE_08]
    end
  endgenerate

  // No enabled form leaves the gate at zero
  assign gate_o = |forms; // [RULE_05] [RULE_11]
endmodule : lcig_gate

// *** hw/lcig_top.sv ***
// Input selection and gating for a configurable logic cell, AXI4-Lite.
// Assumes source signals are synchronous to clk_sys_i.
// Operation
// (RULE_01) Four selectors, six bits each, pick the source for channels 1-4.
// (RULE_02) Selector bits 7 and 6 ignore writes and read as zero.
// (RULE_03) Selectors and gate enables start undefined, kept through reset.
// (RULE_04) Gate 1 enables run chan4 true at bit 7 to chan1 negated at 0.
// (RULE_05) A set enable gates its form in; a clear one has no influence.
// (RULE_06) Gate 2 enables use the same mapping and feed gate two.
// (RULE_07) Gate 2 bit 0 gates channel 1 negated into gate two.
// (RULE_08) Each channel offers true and negated forms, all enables read/write.
// (RULE_09) Reset clears only cell control; selection and gating stay.
// (RULE_10) Each gate output passes straight or inverted by its polarity bit.
// (RULE_11) Gates OR their enabled forms, zero if none, before polarity.
`timescale 1ns/1ps
module lcig_top #(
  parameter int NUM_SRC = lcig_pkg::NUM_SRC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Source signals for the selectors
  input wire logic [NUM_SRC-1:0] src_i,
  // AXI4-Lite write address and data
  input wire logic [lcig_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read
  input wire logic [lcig_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Gate outputs towards the logic function
  output logic gate_one_out_o,
  output logic gate_two_out_o
);
  localparam int SW = lcig_pkg::SRC_SEL_W;
  localparam int NC = lcig_pkg::NUM_CHAN;
  localparam int GW = lcig_pkg::GATE_EN_W;

  // Configuration; only ctl_reg has a reset, the rest keeps its value across rst_i
  logic [SW-1:0] sel_reg [NC];
  logic [GW-1:0] gate1_en_reg;
  logic [GW-1:0] gate2_en_reg;
  logic [1:0] pol_reg;
  logic [7:0] ctl_reg;
  logic [7:0] ctl_next;

  // Bus state and registered gate levels
  logic aw_full_reg;
  logic aw_full_next;
  logic w_full_reg;
  logic w_full_next;
  logic [lcig_pkg::ADDR_W-1:0] wr_addr_reg;
  logic [lcig_pkg::ADDR_W-1:0] rd_addr_reg;
  logic [7:0] wr_byte_reg;
  logic wr_strb_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic bvalid_next;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic rvalid_next;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic gate1_reg;
  logic gate2_reg;

  // Decode
  wire aw_take = s_axi_awvalid_i & awready_reg;
  wire w_take = s_axi_wvalid_i & wready_reg;
  wire ar_take = s_axi_arvalid_i & arready_reg;
  wire do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
  // A write caught by reset is dropped so the settings survive the reset
  wire wr_en = do_write & wr_strb_reg & ~rst_i;
  wire wr_sel0 = wr_addr_reg == lcig_pkg::OFF_DATA1_SEL;
  wire wr_sel1 = wr_addr_reg == lcig_pkg::OFF_DATA2_SEL;
  wire wr_sel2 = wr_addr_reg == lcig_pkg::OFF_DATA3_SEL;
  wire wr_sel3 = wr_addr_reg == lcig_pkg::OFF_DATA4_SEL;
  wire wr_g1 = wr_addr_reg == lcig_pkg::OFF_GATE1_EN;
  wire wr_g2 = wr_addr_reg == lcig_pkg::OFF_GATE2_EN;
  wire wr_ctl = wr_addr_reg == lcig_pkg::OFF_CELL_CTL;
  wire wr_pol = wr_addr_reg == lcig_pkg::OFF_POLARITY;
  wire wr_sta = wr_addr_reg == lcig_pkg::OFF_STATUS;
  wire wr_hit = wr_sel0 | wr_sel1 | wr_sel2 | wr_sel3 | wr_g1 | wr_g2 |
                wr_ctl | wr_pol | wr_sta;
  wire [NC-1:0] wr_sel_vec = {wr_sel3, wr_sel2, wr_sel1, wr_sel0};

  wire [7:0] ar = s_axi_araddr_i;
  wire rd_hit = (ar <= lcig_pkg::OFF_STATUS) && (ar[1:0] == 2'h0);
  logic [7:0] rd_byte;

  // Channel selection and gating
  logic [NC-1:0] chan_true;
  wire cell_en = ctl_reg[lcig_pkg::CTL_EN_BIT];
  wire g1_raw;
  wire g2_raw;
  wire g1_pol = g1_raw ^ pol_reg[lcig_pkg::POL_G1_BIT]; // [RULE_10]
  wire g2_pol = g2_raw ^ pol_reg[lcig_pkg::POL_G2_BIT]; // [RULE_10]

  genvar c;
  generate
    for (c = 0; c < NC; c++) begin : g_chan
      assign chan_true[c] = src_i[sel_reg[c]]; // [RULE_01]
      // Only the low six bits exist; bits 7..6 are dropped
      always_ff @(posedge clk_sys_i) begin
        if (wr_en && wr_sel_vec[c]) begin
          sel_reg[c] <= wr_byte_reg[SW-1:0]; // [RULE_01] [RULE_02] [RULE_03]
        end
      end
    end
  endgenerate

  lcig_gate #(.NUM_CHAN(NC)) u_gate1 (
    .chan_true_i(chan_true),
    .gate_en_i(gate1_en_reg),
    .gate_o(g1_raw)
  );

  lcig_gate #(.NUM_CHAN(NC)) u_gate2 (
    .chan_true_i(chan_true),
    .gate_en_i(gate2_en_reg),
    .gate_o(g2_raw)
  );

  // Gate enables and polarity; rst_i deliberately leaves them alone
  always_ff @(posedge clk_sys_i) begin
    if (wr_en && wr_g1) begin
      gate1_en_reg <= wr_byte_reg; // [RULE_03] [RULE_04] [RULE_08]
    end
    if (wr_en && wr_g2) begin
      gate2_en_reg <= wr_byte_reg; // [RULE_06] [RULE_07] [RULE_08]
    end
    if (wr_en && wr_pol) begin
      pol_reg <= wr_byte_reg[1:0];
    end
  end

  assign ctl_next = (wr_en && wr_ctl) ? (wr_byte_reg & lcig_pkg::CTL_MASK)
                                      : ctl_reg;

  // Disabled cell holds both gates low so outputs are defined after reset
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctl_reg <= lcig_pkg::CTL_RESET; // [RULE_09]
      gate1_reg <= 1'b0;
      gate2_reg <= 1'b0;
    end else begin
      ctl_reg <= ctl_next;
      gate1_reg <= cell_en & g1_pol; // [RULE_05]
      gate2_reg <= cell_en & g2_pol; // [RULE_05]
    end
  end

  // Write channel bookkeeping and read valid
  assign aw_full_next = (aw_full_reg | aw_take) & ~do_write;
  assign w_full_next = (w_full_reg | w_take) & ~do_write;
  assign bvalid_next = do_write | (bvalid_reg & ~s_axi_bready_i);
  assign rvalid_next = ar_take | (rvalid_reg & ~s_axi_rready_i);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= lcig_pkg::RESP_OKAY;
      wr_addr_reg <= '0;
      wr_byte_reg <= 8'h00;
      wr_strb_reg <= 1'b0;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      awready_reg <= ~aw_full_next & ~bvalid_next;
      wready_reg <= ~w_full_next & ~bvalid_next;
      bvalid_reg <= bvalid_next;
      if (do_write) begin
        bresp_reg <= wr_hit ? lcig_pkg::RESP_OKAY : lcig_pkg::RESP_SLVERR;
      end
      if (aw_take) begin
        wr_addr_reg <= s_axi_awaddr_i;
      end
      if (w_take) begin
        wr_byte_reg <= s_axi_wdata_i[7:0];
        wr_strb_reg <= s_axi_wstrb_i[0];
      end
    end
  end

  // Read mux; unused bits read zero
  always_comb begin
    rd_byte = 8'h00;
    case (ar)
      lcig_pkg::OFF_DATA1_SEL: rd_byte = {2'h0, sel_reg[0]}; // [RULE_02]
      lcig_pkg::OFF_DATA2_SEL: rd_byte = {2'h0, sel_reg[1]}; // [RULE_02]
      lcig_pkg::OFF_DATA3_SEL: rd_byte = {2'h0, sel_reg[2]}; // [RULE_02]
      lcig_pkg::OFF_DATA4_SEL: rd_byte = {2'h0, sel_reg[3]}; // [RULE_02]
      lcig_pkg::OFF_GATE1_EN: rd_byte = gate1_en_reg; // [RULE_08]
      lcig_pkg::OFF_GATE2_EN: rd_byte = gate2_en_reg; // [RULE_08]
      lcig_pkg::OFF_CELL_CTL: rd_byte = ctl_reg;
      lcig_pkg::OFF_POLARITY: rd_byte = {6'h00, pol_reg};
      lcig_pkg::OFF_STATUS: rd_byte = {6'h00, gate2_reg, gate1_reg};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= lcig_pkg::RESP_OKAY;
      rd_addr_reg <= '0;
    end else begin
      arready_reg <= ~rvalid_next;
      rvalid_reg <= rvalid_next;
      if (ar_take) begin
        rdata_reg <= {24'h00_0000, rd_byte};
        rresp_reg <= rd_hit ? lcig_pkg::RESP_OKAY : lcig_pkg::RESP_SLVERR;
        rd_addr_reg <= ar;
      end
    end
  end

  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o = wready_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign gate_one_out_o = gate1_reg;
  assign gate_two_out_o = gate2_reg;

  a_sel_top_zero: assert property ( // [RULE_02]
    @(posedge clk_sys_i) disable iff (rst_i)
    (rvalid_reg && rd_addr_reg <= lcig_pkg::OFF_DATA4_SEL)
      |-> rdata_reg[7:6] == 2'h0)
    else $error("selector read shows upper bits set");

  a_sel_write_lands: assert property ( // [RULE_01]
    @(posedge clk_sys_i) disable iff (rst_i)
    (wr_en && wr_sel0) |=> sel_reg[0] == $past(wr_byte_reg[5:0]))
    else $error("selector write not stored");

  a_sel4_write_lands: assert property ( // [RULE_01] [RULE_02]
    @(posedge clk_sys_i) disable iff (rst_i)
    (wr_en && wr_sel3) |=> sel_reg[3] == $past(wr_byte_reg[5:0]))
    else $error("channel four selector write not stored");

  a_cfg_kept_reset: assert property ( // [RULE_03]
    @(posedge clk_sys_i)
    rst_i |=> (gate1_en_reg === $past(gate1_en_reg))
      && (sel_reg[3] === $past(sel_reg[3])))
    else $error("configuration changed by reset");

  a_ctl_reset_clear: assert property ( // [RULE_09]
    @(posedge clk_sys_i)
    rst_i |=> ctl_reg == lcig_pkg::CTL_RESET)
    else $error("cell control not cleared by reset");

  a_cell_off_low: assert property ( // [RULE_09]
    @(posedge clk_sys_i) disable iff (rst_i)
    !cell_en |=> !gate_one_out_o && !gate_two_out_o)
    else $error("disabled cell drives a gate high");

  a_ctl_top_zero: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    ctl_reg[6:5] == 2'h0)
    else $error("cell control unused bits not zero");

  a_g1_chan1_true: assert property ( // [RULE_04]
    @(posedge clk_sys_i) disable iff (rst_i)
    (cell_en && gate1_en_reg == 8'h02 && !pol_reg[0])
      |=> gate_one_out_o == $past(src_i[sel_reg[0]]))
    else $error("gate one does not follow channel one");

  a_g1_chan1_neg: assert property ( // [RULE_08]
    @(posedge clk_sys_i) disable iff (rst_i)
    (cell_en && gate1_en_reg == 8'h01 && !pol_reg[0])
      |=> gate_one_out_o == !$past(src_i[sel_reg[0]]))
    else $error("gate one does not follow negated channel one");

  a_g2_chan4_true: assert property ( // [RULE_06]
    @(posedge clk_sys_i) disable iff (rst_i)
    (cell_en && gate2_en_reg == 8'h80 && !pol_reg[1])
      |=> gate_two_out_o == $past(src_i[sel_reg[3]]))
    else $error("gate two does not follow channel four");

  a_g2_chan1_neg: assert property ( // [RULE_07]
    @(posedge clk_sys_i) disable iff (rst_i)
    (cell_en && gate2_en_reg[0] && !chan_true[0] && !pol_reg[1])
      |=> gate_two_out_o)
    else $error("negated channel one not gated into gate two");

  a_gate_none_low: assert property ( // [RULE_11]
    @(posedge clk_sys_i) disable iff (rst_i)
    (gate1_en_reg == 8'h00 && !pol_reg[0]) |=> !gate_one_out_o)
    else $error("gate one high with no form enabled");

  a_g2_none_low: assert property ( // [RULE_11]
    @(posedge clk_sys_i) disable iff (rst_i)
    (gate2_en_reg == 8'h00 && !pol_reg[1]) |=> !gate_two_out_o)
    else $error("gate two high with no form enabled");

  a_gate_polarity: assert property ( // [RULE_10] [RULE_05]
    @(posedge clk_sys_i) disable iff (rst_i)
    (cell_en && gate1_en_reg == 8'h00 && pol_reg[0])
      ##1 (cell_en && pol_reg[0]) |-> gate_one_out_o)
    else $error("inverted empty gate not high");

  a_g2_polarity: assert property ( // [RULE_10]
    @(posedge clk_sys_i) disable iff (rst_i)
    (cell_en && gate2_en_reg == 8'h00 && pol_reg[1])
      |=> gate_two_out_o)
    else $error("inverted empty gate two not high");

  a_write_answer: assert property ( // [RULE_08]
    @(posedge clk_sys_i) disable iff (rst_i)
    do_write |=> s_axi_bvalid_o && !s_axi_awready_o)
    else $error("write not answered next cycle");

  a_write_slverr: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (do_write && !wr_hit) |=> s_axi_bresp_o == lcig_pkg::RESP_SLVERR)
    else $error("unmapped write not answered with an error");

  a_read_answer: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    ar_take |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read not answered next cycle");
endmodule : lcig_top

// *** dv/lcig_tb.sv ***
// Self-checking bench for the logic cell input gating block.
// Assumes lcig_top answers AXI4-Lite as handed over; no partner model.
`timescale 1ns/1ps
module tb;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [63:0] src = '0;
  logic [7:0] awaddr = '0;
  logic [7:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic [3:0] ws = 4'h1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, g1, g2;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  logic [63:0] sv;
  logic [7:0] en;
  logic e1, e2;
  logic [7:0] sw [4] = '{8'hff, 8'hc0, 8'h55, 8'h6a};
  int n_fail = 0, num_checks = 0, cyc = 0;

  lcig_top dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .src_i(src),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready),
    .gate_one_out_o(g1), .gate_two_out_o(g2)
  );

  always #4 clk_sys_i = ~clk_sys_i;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  // Generous ceiling; the full sequence needs fewer than 1500 cycles
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    output logic [1:0] r);
    @(posedge clk_sys_i);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= ws;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk_sys_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : wr

  task automatic rdr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    @(posedge clk_sys_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk_sys_i);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : rdr

  // Expected gate level from the enable byte and the four channel values
  function automatic logic gx(input logic [7:0] e, input logic [3:0] c);
    gx = |(e & {c[3], ~c[3], c[2], ~c[2], c[1], ~c[1], c[0], ~c[0]});
  endfunction : gx

  initial begin
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    // Channel 1 takes src 63, 2 takes 0, 3 takes 21, 4 takes 42
    for (int i = 0; i < 4; i++) begin
      wr(8'(i * 4), sw[i], rs);
      chk(32'(rs), 32'h0);
    end
    for (int i = 0; i < 4; i++) begin
      rdr(8'(i * 4), rd, rs);
      chk(rd, {24'h0, sw[i] & 8'h3f});
    end
    wr(8'h10, 8'ha5, rs);
    wr(8'h14, 8'h5a, rs);
    rdr(8'h10, rd, rs);
    chk(rd, 32'h0000_00a5);
    rdr(8'h14, rd, rs);
    chk(rd, 32'h0000_005a);
    wr(8'h18, 8'h80, rs);
    for (int pol = 0; pol < 2; pol++) begin
      wr(8'h1c, 8'(pol * 3), rs);
      for (int k = 0; k < 10; k++) begin
        en = (k < 8) ? 8'(1 << k) : ((k == 8) ? 8'h00 : 8'h96);
        wr(8'h10, en, rs);
        wr(8'h14, {en[6:0], en[7]}, rs);
        for (int p = 0; p < 16; p++) begin
          sv = '0;
          sv[63] = p[0];
          sv[0] = p[1];
          sv[21] = p[2];
          sv[42] = p[3];
          @(posedge clk_sys_i);
          src <= sv;
          repeat (2) @(posedge clk_sys_i);
          e1 = gx(en, p[3:0]) ^ pol[0];
          e2 = gx({en[6:0], en[7]}, p[3:0]) ^ pol[0];
          chk(32'(g1), 32'(e1));
          chk(32'(g2), 32'(e2));
        end
      end
    end
    // All four selected channels high: gate one still inverted to low, gate two no longer inverted, now high
    wr(8'h1c, 8'h01, rs);
    rdr(8'h1c, rd, rs);
    chk(rd, 32'h0000_0001);
    rdr(8'h20, rd, rs);
    chk(rd, 32'h0000_0002);
    chk(32'(rs), 32'h0);
    // A reset in mid-run clears the cell enable only
    wr(8'h10, 8'h3c, rs);
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    chk(32'(g1), 32'h0);
    rdr(8'h18, rd, rs);
    chk(rd, 32'h0);
    rdr(8'h10, rd, rs);
    chk(rd, 32'h0000_003c);
    for (int i = 0; i < 4; i++) begin
      rdr(8'(i * 4), rd, rs);
      chk(rd, {24'h0, sw[i] & 8'h3f});
    end
    rdr(8'h1c, rd, rs);
    chk(rd, 32'h0000_0001);
    // A write with its byte strobe low must leave the register alone
    ws = 4'h0;
    wr(8'h10, 8'hff, rs);
    ws = 4'h1;
    chk(32'(rs), 32'h0);
    rdr(8'h10, rd, rs);
    chk(rd, 32'h0000_003c);
    wr(8'h18, 8'hff, rs);
    rdr(8'h18, rd, rs);
    chk(rd, 32'h0000_009f);
    rdr(8'h24, rd, rs);
    chk({rd[31:2], rs}, 32'h2);
    wr(8'h24, 8'hff, rs);
    chk(32'(rs), 32'h2);
    stop_test();
  end
endmodule : tb
